/* File: pkg/self_test_pkg.sv */
/*
 Constants for the drive self-test sequencer: register map, field
 positions, function codes, result codes, sense codes and timing.
 Assumes a 100 MHz APB clock.
*/
package self_test_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_CMD      = 8'h00;
   localparam logic [7:0] OFF_STATUS   = 8'h04;
   localparam logic [7:0] OFF_LOG_SEL  = 8'h08;
   localparam logic [7:0] OFF_LOG_HDR  = 8'h0C;
   localparam logic [7:0] OFF_LOG_LBA  = 8'h10;
   localparam logic [7:0] OFF_EXT_DUR  = 8'h14;
   localparam logic [7:0] OFF_LOG_CNT  = 8'h18;

   // Function code sits in bits 7:5 of command byte 1
   localparam int FC_MSB = 7;
   localparam int FC_LSB = 5;
   localparam logic [2:0] FC_SHORT    = 3'h1;
   localparam logic [2:0] FC_EXTENDED = 3'h2;
   localparam logic [2:0] FC_ABORT    = 3'h4;

   // Result values
   localparam logic [3:0] RES_PASS      = 4'h0;
   localparam logic [3:0] RES_ABORT_APP = 4'h1;
   localparam logic [3:0] RES_ABORT_RST = 4'h2;
   localparam logic [3:0] RES_FAIL_ELEC = 4'h5;
   localparam logic [3:0] RES_FAIL_SRV  = 4'h6;
   localparam logic [3:0] RES_FAIL_SCAN = 4'h7;
   localparam logic [3:0] RES_RUNNING   = 4'hF;

   // Not-ready sense data
   localparam logic [3:0] SK_NOT_READY   = 4'h2;
   localparam logic [7:0] ASC_NOT_READY  = 8'h04;
   localparam logic [7:0] ASCQ_CAUSE_NR  = 8'h00;
   localparam logic [7:0] ASCQ_MANUAL_NR = 8'h03;

   // Log depth
   localparam int LOG_DEPTH = 20;
   localparam logic [4:0] LOG_DEPTH_W = 5'd20;

   // Status field positions
   localparam int ST_BUSY     = 0;
   localparam int ST_NOTRDY   = 1;
   localparam int ST_REFUSED  = 2;
   localparam int ST_SEG_LSB  = 4;
   localparam int ST_SK_LSB   = 8;
   localparam int ST_ASC_LSB  = 16;
   localparam int ST_ASCQ_LSB = 24;

   // Timing
   localparam longint CLK_HZ         = 100_000_000;
   localparam longint SHORT_LIMIT_S  = 120;
   localparam longint SHORT_LIMIT_CY = SHORT_LIMIT_S * CLK_HZ;
   localparam logic [31:0] EXT_DUR_S = 32'h0000_0E10;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'b00001,
      ST_ELEC  = 5'b00010,
      ST_SERVO = 5'b00100,
      ST_SCAN  = 5'b01000,
      ST_DONE  = 5'b10000
   } seq_state_e;

   typedef struct packed {
      logic [2:0]  func;
      logic [3:0]  result;
      logic [3:0]  sk;
      logic [7:0]  asc;
      logic [7:0]  ascq;
      logic [7:0]  fru;
      logic        lba_valid;
      logic [31:0] lba;
   } log_entry_s;
endpackage : self_test_pkg

/* File: hw/self_test_seq.sv */
/*
 Drive self-test sequencer with APB register access and a 20-entry
 results log. Assumes the drive firmware runs each segment when told,
 pulses seg_done or seg_fail, and retries internally before failing.
*/
// The address map and the APB register port were chosen for this implementation.
// Overview of operation
// - Function code in byte 1 bits 7:5; 001b short, 010b extended.
// - Not ready on motor spin, speed lock, servo lock or config read failure.
// - Not ready status reports sense 02/04/00 or 02/04/03.
// - Failure only for seek, track, read or write error after retries.
// - All retries and recovery kept; parameters never tightened.
// - Recovered errors never reported as diagnostic failures.
// - Each test runs electrical, servo, then read/verify scan segments.
// - Short test ends at 120 s only once in the scan segment (limit checked there alone) and scans only media portions.
// - Extended test scans every block and exercises read/write/read.
// - Extended test duration published for the host to read.
// - Start inserts new entry at log head, older entries shift back.
// - Log keeps 20 entries; the oldest is dropped.
// - New entry gets function code and result Fh, then log is saved.
// - On completion or abort the result is rewritten and saved.
// - Result is 4 bits: zero pass, nonzero failure reason.
// - Failure records sense key, ASC, ASCQ, FRU and LBA if any.
// - Abort function code stops the test, result 01.
// - Bus or device reset stops the test, result 02.
`timescale 1ns/1ps
module self_test_seq #(
   parameter longint SHORT_LIMIT = self_test_pkg::SHORT_LIMIT_CY
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic        motor_no_spin,
   input  wire logic        motor_no_lock,
   input  wire logic        servo_no_lock,
   input  wire logic        config_read_fail,
   input  wire logic        bus_reset,
   input  wire logic        device_reset_msg,
   input  wire logic        seg_done,
   input  wire logic        seg_fail,
   input  wire logic [3:0]  fail_sk,
   input  wire logic [7:0]  fail_asc,
   input  wire logic [7:0]  fail_ascq,
   input  wire logic [7:0]  fail_fru,
   input  wire logic        fail_lba_valid,
   input  wire logic [31:0] fail_lba,
   output logic             seg_start,
   output logic [2:0]       seg_select,
   output logic             full_scan,
   output logic             rwr_enable,
   output logic             retries_full,
   output logic             nv_save
);
   import self_test_pkg::*;

   typedef struct packed {
      seq_state_e              state;
      log_entry_s [LOG_DEPTH-1:0] log_q;
      logic [4:0]              count;
      logic [4:0]              sel;
      logic [2:0]              func;
      logic [33:0]             timer;
      logic                    refused;
      logic                    pready;
      logic [31:0]             prdata;
      logic                    pslverr;
      logic                    seg_start;
      logic [2:0]              seg_select;
      logic                    full_scan;
      logic                    rwr_enable;
      logic                    nv_save;
      logic                    retries_full;
   } seq_s;

   seq_s q;
   seq_s next_q;

   localparam logic [33:0] LIMIT = SHORT_LIMIT[33:0];

   function automatic logic known_offset(input logic [31:0] a);
      known_offset = (a[31:8] == 24'h0) && (a[1:0] == 2'b00) &&
                     (a[7:0] <= OFF_LOG_CNT);
   endfunction : known_offset

   function automatic logic [3:0] seg_fail_code(input seq_state_e s);
      case (s)
         ST_ELEC:  seg_fail_code = RES_FAIL_ELEC;
         ST_SERVO: seg_fail_code = RES_FAIL_SRV;
         default:  seg_fail_code = RES_FAIL_SCAN;
      endcase
   endfunction : seg_fail_code

   logic       not_ready;
   logic [7:0] nr_ascq;
   logic       running;
   logic       apb_setup;
   logic       apb_access;
   logic       cmd_write;
   logic [2:0] wr_func;
   logic       start_req;
   logic       any_reset;
   log_entry_s sel_entry;

   assign not_ready = motor_no_spin | motor_no_lock | servo_no_lock | config_read_fail;
   // Config table loss needs intervention, others report cause not reportable
   assign nr_ascq   = config_read_fail ? ASCQ_MANUAL_NR : ASCQ_CAUSE_NR;
   assign running   = (q.state != ST_IDLE);
   assign apb_setup  = psel & ~penable;
   assign apb_access = psel & penable & q.pready;
   assign cmd_write  = apb_access & pwrite & (paddr[7:0] == OFF_CMD) & known_offset(paddr);
   // Function code field of byte 1
   assign wr_func    = pwdata[FC_MSB:FC_LSB];
   // Start while not ready or busy is refused, not queued
   assign start_req  = cmd_write & ~running & ~not_ready &
                       ((wr_func == FC_SHORT) | (wr_func == FC_EXTENDED));
   assign any_reset  = bus_reset | device_reset_msg;
   assign sel_entry  = q.log_q[q.sel];

   always_comb begin
      next_q = q;
      next_q.seg_start = 1'b0;
      next_q.nv_save   = 1'b0;
      // Retry and recovery are never reduced by this block
      next_q.retries_full = 1'b1;

      // Registered APB answer: ready in the cycle after setup
      next_q.pready  = apb_setup;
      next_q.pslverr = 1'b0;
      if (apb_setup) begin
         next_q.pslverr = ~known_offset(paddr);
         next_q.prdata  = 32'h0000_0000;
         if (!pwrite && known_offset(paddr)) begin
            case (paddr[7:0])
               OFF_CMD:     next_q.prdata = {24'h0, q.func, 5'h00};
               OFF_STATUS: begin
                  next_q.prdata[ST_BUSY]    = running;
                  next_q.prdata[ST_NOTRDY]  = not_ready;
                  next_q.prdata[ST_REFUSED] = q.refused;
                  next_q.prdata[ST_SEG_LSB +: 3] = q.seg_select;
                  if (not_ready) begin
                     next_q.prdata[ST_SK_LSB +: 4]   = SK_NOT_READY;
                     next_q.prdata[ST_ASC_LSB +: 8]  = ASC_NOT_READY;
                     next_q.prdata[ST_ASCQ_LSB +: 8] = nr_ascq;
                  end
               end
               OFF_LOG_SEL: next_q.prdata = {27'h0, q.sel};
               // Only the low FRU nibble fits beside the other fields
               OFF_LOG_HDR: next_q.prdata = {sel_entry.fru[3:0], sel_entry.ascq,
                                             sel_entry.asc, sel_entry.sk,
                                             sel_entry.lba_valid, sel_entry.func,
                                             sel_entry.result};
               OFF_LOG_LBA: next_q.prdata = sel_entry.lba;
               OFF_EXT_DUR: next_q.prdata = EXT_DUR_S;
               OFF_LOG_CNT: next_q.prdata = {27'h0, q.count};
               default:     next_q.prdata = 32'h0000_0000;
            endcase
         end
      end

      if (apb_access && pwrite && (paddr[7:0] == OFF_LOG_SEL) && known_offset(paddr)) begin
         next_q.sel = (pwdata[4:0] < LOG_DEPTH_W) ? pwdata[4:0] : q.sel;
      end

      if (cmd_write && (wr_func == FC_SHORT || wr_func == FC_EXTENDED)) begin
         next_q.refused = ~start_req;
      end

      if (running) begin
         next_q.timer = q.timer + 34'd1;
      end

      case (q.state)
         ST_IDLE: begin
            if (start_req) begin
               // Shift log back, new entry at head
               for (int i = LOG_DEPTH-1; i > 0; i--) begin
                  next_q.log_q[i] = q.log_q[i-1];
               end
               // Head entry: function code and Fh
               next_q.log_q[0]        = '0;
               next_q.log_q[0].func   = wr_func;
               next_q.log_q[0].result = RES_RUNNING;
               next_q.nv_save         = 1'b1;
               // Saturate at depth, oldest fell off the end
               if (q.count < LOG_DEPTH_W) begin
                  next_q.count = q.count + 5'd1;
               end
               next_q.func  = wr_func;
               next_q.timer = '0;
               // Full scan and read/write/read only when extended
               next_q.full_scan  = (wr_func == FC_EXTENDED);
               next_q.rwr_enable = (wr_func == FC_EXTENDED);
               next_q.state      = ST_ELEC;
               next_q.seg_select = 3'b001;
               next_q.seg_start  = 1'b1;
            end
         end
         ST_ELEC, ST_SERVO, ST_SCAN: begin
            if (any_reset) begin
               next_q.log_q[0].result = RES_ABORT_RST;
               next_q.state           = ST_DONE;
            end else if (cmd_write && wr_func == FC_ABORT) begin
               next_q.log_q[0].result = RES_ABORT_APP;
               next_q.state           = ST_DONE;
            end else if (seg_fail) begin
               // Only unrecovered errors after retries arrive here
               next_q.log_q[0].result    = seg_fail_code(q.state);
               next_q.log_q[0].sk        = fail_sk;
               next_q.log_q[0].asc       = fail_asc;
               next_q.log_q[0].ascq      = fail_ascq;
               next_q.log_q[0].fru       = fail_fru;
               next_q.log_q[0].lba_valid = fail_lba_valid;
               next_q.log_q[0].lba       = fail_lba;
               next_q.state              = ST_DONE;
            end else if (q.state == ST_SCAN && q.func == FC_SHORT &&
                         q.timer >= LIMIT - 34'd1) begin
               // Time budget spent, partial scan counts as pass
               next_q.log_q[0].result = RES_PASS;
               next_q.state           = ST_DONE;
            end else if (seg_done) begin
               case (q.state)
                  ST_ELEC: begin
                     next_q.state      = ST_SERVO;
                     next_q.seg_select = 3'b010;
                     next_q.seg_start  = 1'b1;
                  end
                  ST_SERVO: begin
                     next_q.state      = ST_SCAN;
                     next_q.seg_select = 3'b100;
                     next_q.seg_start  = 1'b1;
                  end
                  default: begin
                     next_q.log_q[0].result = RES_PASS;
                     next_q.state           = ST_DONE;
                  end
               endcase
            end
            // Otherwise the head result stays Fh
         end
         ST_DONE: begin
            next_q.nv_save    = 1'b1;
            next_q.seg_select = 3'b000;
            next_q.full_scan  = 1'b0;
            next_q.rwr_enable = 1'b0;
            next_q.state      = ST_IDLE;
         end
         default: next_q.state = ST_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q       <= '0;
         q.state <= ST_IDLE;
      end else begin
         q <= next_q;
      end
   end

   assign pready     = q.pready;
   assign prdata     = q.prdata;
   assign pslverr    = q.pslverr;
   assign seg_start  = q.seg_start;
   assign seg_select = q.seg_select;
   assign full_scan  = q.full_scan;
   assign rwr_enable = q.rwr_enable;
   assign nv_save    = q.nv_save;
   assign retries_full = q.retries_full;
endmodule : self_test_seq

/* File: verification/drive_fw_model.sv */
/*
 Behavioural drive firmware that runs one self-test segment per seg_start.
 Assumes seg_select is valid with seg_start and drops to zero on abort.
*/
`timescale 1ns/1ps
module drive_fw_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        seg_start,
   input  wire logic [2:0]  seg_select,
   input  wire logic [15:0] lat,
   input  wire logic [2:0]  fail_sel,
   output logic             seg_done,
   output logic             seg_fail,
   output logic [3:0]       fail_sk,
   output logic [7:0]       fail_asc,
   output logic [7:0]       fail_ascq,
   output logic [7:0]       fail_fru,
   output logic             fail_lba_valid,
   output logic [31:0]      fail_lba
);
   logic [15:0] cnt;
   logic        act;
   logic [2:0]  seg;

   // retries stay inside firmware
   // Only a commanded unrecovered error pulses seg_fail
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act      <= 1'b0;
         cnt      <= 16'h0;
         seg      <= 3'h0;
         seg_done <= 1'b0;
         seg_fail <= 1'b0;
      end else begin
         seg_done <= 1'b0;
         seg_fail <= 1'b0;
         if (seg_start) begin
            act <= 1'b1;
            cnt <= lat;
            seg <= seg_select;
         end else if (act && seg_select == 3'h0) begin
            act <= 1'b0;
         end else if (act && cnt != 16'h0) begin
            cnt <= cnt - 16'h1;
         end else if (act) begin
            act      <= 1'b0;
            seg_fail <= |(seg & fail_sel);
            seg_done <= ~|(seg & fail_sel);
         end
      end
   end

   // Details are only meaningful with seg_fail; inverted otherwise
   assign fail_sk        = seg_fail ? 4'h3 : 4'hC;
   assign fail_asc       = seg_fail ? 8'h11 : 8'hEE;
   assign fail_ascq      = seg_fail ? 8'h04 : 8'hFB;
   assign fail_fru       = seg_fail ? 8'h5A : 8'hA5;
   assign fail_lba_valid = seg_fail;
   assign fail_lba       = seg_fail ? 32'h0001_2345 : 32'hFFFE_DCBA;
endmodule : drive_fw_model

/* File: verification/self_test_seq_sva.sv */
/*
 Assertion checker for self_test_seq, bound to its ports.
 Assumes a single clock domain with asynchronous active-low reset.
*/
`timescale 1ns/1ps
module self_test_seq_chk (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pready,
   input wire logic       motor_no_spin,
   input wire logic       motor_no_lock,
   input wire logic       servo_no_lock,
   input wire logic       config_read_fail,
   input wire logic       bus_reset,
   input wire logic       seg_done,
   input wire logic       seg_fail,
   input wire logic       seg_start,
   input wire logic [2:0] seg_select,
   input wire logic       full_scan,
   input wire logic       rwr_enable,
   input wire logic       retries_full,
   input wire logic       nv_save
);
   logic not_rdy;
   assign not_rdy = motor_no_spin | motor_no_lock | servo_no_lock | config_read_fail;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_retry_full: assert property ($past(presetn) |-> retries_full)
      else $error("retries_full low while running");
   chk_start_pulse: assert property (seg_start |=> !seg_start)
      else $error("seg_start longer than one cycle");
   chk_seg_onehot: assert property ($onehot0(seg_select))
      else $error("seg_select not one-hot");
   chk_elec_first: assert property (
      seg_start && seg_select == 3'b001 |-> nv_save && $past(seg_select) == 3'b000)
      else $error("test start without log save");
   chk_servo_order: assert property (
      seg_start && seg_select == 3'b010 |-> $past(seg_select) == 3'b001 && $past(seg_done))
      else $error("servo segment out of order");
   chk_scan_order: assert property (
      seg_start && seg_select == 3'b100 |-> $past(seg_select) == 3'b010 && $past(seg_done))
      else $error("scan segment out of order");
   chk_nr_refuse: assert property (
      not_rdy && $past(not_rdy) && seg_select == 3'b000 |=> !seg_start)
      else $error("test started while not ready");
   chk_end_saves: assert property (seg_done && seg_select == 3'b100 |-> ##[1:3] nv_save)
      else $error("no log save after completion");
   chk_abort_saves: assert property (bus_reset && seg_select != 3'b000 |-> ##[1:3] nv_save)
      else $error("no log save after reset abort");
   chk_ext_modes: assert property (full_scan == rwr_enable)
      else $error("full_scan and rwr_enable disagree");
   chk_ready_next: assert property (psel && !penable |=> pready)
      else $error("pready missing in access phase");

   cov_scan_done: cover property (seg_done && seg_select == 3'b100);
   cov_fail: cover property (seg_fail);
   cov_reset_abort: cover property (bus_reset && seg_select != 3'b000);
endmodule : self_test_seq_chk

bind self_test_seq self_test_seq_chk chk_i (.*);

/* File: verification/drive_self_test_sequencer_test.sv */
/*
 Self-checking bench for self_test_seq over APB with a firmware model.
 Assumes zero-wait APB answers and a shortened short-test limit.
*/
`timescale 1ns/1ps
module drive_self_test_sequencer_test;
   import self_test_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [31:0] paddr, pwdata, prdata, fail_lba, rd;
   logic        motor_no_spin, motor_no_lock, servo_no_lock, config_read_fail;
   logic        bus_reset, device_reset_msg, seg_done, seg_fail, fail_lba_valid;
   logic [3:0]  fail_sk;
   logic [7:0]  fail_asc, fail_ascq, fail_fru;
   logic        seg_start, full_scan, rwr_enable, retries_full, nv_save;
   logic [2:0]  seg_select, fail_sel;
   logic [15:0] lat;
   logic [6:0]  exp_q[$];
   int          n_mismatch = 0;
   int          compares = 0;

   self_test_seq #(.SHORT_LIMIT(200)) dut (.*);
   drive_fw_model fw (.*);

   initial pclk = 1'b0;
   always #5 pclk = ~pclk;

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task print_verdict;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : print_verdict

   // Entered just after a rising edge; holds the request until pready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {24'h0, a};
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // Idle edge, so a following call never re-drives psel in this step
      @(posedge pclk);
   endtask : apb

   task automatic wait_idle;
      int n;
      n = 0;
      do begin
         apb(1'b0, OFF_STATUS, 32'h0);
         n++;
      end while (rd[ST_BUSY] !== 1'b0 && n < 1000);
      check("busy", {31'h0, rd[ST_BUSY]}, 32'h0);
   endtask : wait_idle

   task automatic run(input logic [2:0] fc, input logic [15:0] l, input logic [2:0] fs,
                      input int how, input logic [3:0] res);
      lat      <= l;
      fail_sel <= fs;
      apb(1'b1, OFF_CMD, {24'h0, fc, 5'h0});
      apb(1'b0, OFF_LOG_HDR, 32'h0);
      check("head_running", {25'h0, rd[6:0]}, {25'h0, fc, RES_RUNNING});
      check("full_scan", {31'h0, full_scan}, {31'h0, fc == FC_EXTENDED});
      if (how == 1) apb(1'b1, OFF_CMD, {24'h0, FC_ABORT, 5'h0});
      if (how == 2) bus_reset <= 1'b1;
      if (how == 3) device_reset_msg <= 1'b1;
      if (how > 1) begin
         @(posedge pclk);
         bus_reset        <= 1'b0;
         device_reset_msg <= 1'b0;
      end
      wait_idle();
      apb(1'b0, OFF_LOG_HDR, 32'h0);
      check("head_result", {25'h0, rd[6:0]}, {25'h0, fc, res});
      exp_q.push_front({fc, res});
      if (exp_q.size() > LOG_DEPTH) void'(exp_q.pop_back());
   endtask : run

   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {motor_no_spin, motor_no_lock, servo_no_lock, config_read_fail} = 4'h0;
      {bus_reset, device_reset_msg, fail_sel} = '0;
      lat = 16'h4;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, OFF_EXT_DUR, 32'h0);
      check("ext_dur", rd, EXT_DUR_S);
      apb(1'b0, 8'h1C, 32'h0);
      check("unmapped_err", {31'h0, err}, 32'h1);
      check("unmapped_rd", rd, 32'h0);
      for (int i = 0; i < 4; i++) begin
         {motor_no_spin, motor_no_lock, servo_no_lock, config_read_fail} <= 4'h8 >> i;
         repeat (2) @(posedge pclk);
         apb(1'b1, OFF_CMD, {24'h0, FC_SHORT, 5'h0});
         apb(1'b0, OFF_STATUS, 32'h0);
         check("not_ready", rd & 32'hFFFF_0F06, {(i == 3) ? ASCQ_MANUAL_NR : ASCQ_CAUSE_NR,
               ASC_NOT_READY, 4'h0, SK_NOT_READY, 8'h06});
      end
      {motor_no_spin, motor_no_lock, servo_no_lock, config_read_fail} <= 4'h0;
      repeat (2) @(posedge pclk);
      apb(1'b0, OFF_LOG_CNT, 32'h0);
      check("refused_no_entry", rd, 32'h0);
      apb(1'b1, OFF_LOG_SEL, 32'h0);
      run(FC_SHORT, 16'h4, 3'b000, 0, RES_PASS);
      run(FC_EXTENDED, 16'h6, 3'b100, 0, RES_FAIL_SCAN);
      apb(1'b0, OFF_LOG_HDR, 32'h0);
      check("fail_detail", rd,
            {4'hA, 8'h04, 8'h11, 4'h3, 1'b1, FC_EXTENDED, RES_FAIL_SCAN});
      apb(1'b0, OFF_LOG_LBA, 32'h0);
      check("fail_lba", rd, 32'h0001_2345);
      run(FC_SHORT, 16'h4, 3'b001, 0, RES_FAIL_ELEC);
      run(FC_SHORT, 16'h4, 3'b010, 0, RES_FAIL_SRV);
      // Scan would fail if the time budget did not end it first
      run(FC_SHORT, 16'h190, 3'b100, 0, RES_PASS);
      run(FC_EXTENDED, 16'h1E, 3'b000, 2, RES_ABORT_RST);
      run(FC_SHORT, 16'h1E, 3'b000, 3, RES_ABORT_RST);
      for (int i = 0; i < 16; i++) run(FC_SHORT, 16'h1E, 3'b000, 1, RES_ABORT_APP);
      apb(1'b0, OFF_LOG_CNT, 32'h0);
      check("log_cnt_full", rd, 32'h14);
      for (int i = 0; i < LOG_DEPTH; i++) begin
         apb(1'b1, OFF_LOG_SEL, 32'(i));
         apb(1'b0, OFF_LOG_HDR, 32'h0);
         check("log_entry", {25'h0, rd[6:0]}, {25'h0, exp_q[i]});
      end
      print_verdict();
   end

   // Whole run needs well under 20000 cycles
   initial begin
      repeat (60000) @(posedge pclk);
      n_mismatch++;
      print_verdict();
   end
endmodule : drive_self_test_sequencer_test
